/* File: logic/sdi_consts.svh */
`ifndef SDI_CONSTS_SVH
`define SDI_CONSTS_SVH
// serial word and converter code geometry
`define SDI_WORD_BITS   16
`define SDI_CODE_BITS   12
`define SDI_CNT_BITS    5
`define SDI_LAST_BIT    5'h10
`define SDI_CNT_ZERO    5'h00
`define SDI_CNT_ONE     5'h01
`define SDI_CODE_MSB    11
`define SDI_PD_MSB      13
`define SDI_PD_LSB      12
`define SDI_CODE_RST    12'h000
`define SDI_PD_RST      2'h0
`define SDI_WORD_RST    16'h0000
// buffer geometry
`define SDI_FIFO_DEPTH  4
`define SDI_PTR_BITS    2
`define SDI_FILL_BITS   3
`endif

/* File: logic/sdi_fifo.sv */
`timescale 1ns/1ps
`include "sdi_consts.svh"
module sdi_fifo #(
	parameter int WIDTH = `SDI_WORD_BITS,
	parameter int DEPTH = `SDI_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             CLK,
	input  wire logic             NRST,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0]         mem_r [DEPTH];
	logic [`SDI_PTR_BITS-1:0] wr_r;
	logic [`SDI_PTR_BITS-1:0] wr_nxt;
	logic [`SDI_PTR_BITS-1:0] rd_r;
	logic [`SDI_PTR_BITS-1:0] rd_nxt;
	logic [`SDI_FILL_BITS-1:0] fill_r;
	logic [`SDI_FILL_BITS-1:0] fill_nxt;
	logic                     push;
	logic                     pop;

	// honest flags from the fill count
	assign in_ready  = (fill_r != DEPTH[`SDI_FILL_BITS-1:0]);
	assign out_valid = (fill_r != '0);
	assign out_data  = mem_r[rd_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer and count next values
	always_comb begin
		wr_nxt   = push ? wr_r + 1'b1 : wr_r;
		rd_nxt   = pop ? rd_r + 1'b1 : rd_r;
		fill_nxt = fill_r;
		if (push && !pop) begin
			fill_nxt = fill_r + 1'b1;
		end else if (pop && !push) begin
			fill_nxt = fill_r - 1'b1;
		end
	end

	// registers; storage needs no reset
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wr_r   <= '0;
			rd_r   <= '0;
			fill_r <= '0;
		end else begin
			wr_r   <= wr_nxt;
			rd_r   <= rd_nxt;
			fill_r <= fill_nxt;
		end
	end

	always_ff @(posedge CLK) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end
endmodule : sdi_fifo

/* File: logic/sdi_pkg.sv */
`include "sdi_consts.svh"
package sdi_pkg;
	typedef logic [`SDI_WORD_BITS-1:0] sdi_word_t;
	typedef logic [`SDI_CODE_BITS-1:0] sdi_code_t;
	typedef logic [`SDI_CNT_BITS-1:0]  sdi_cnt_t;
	typedef enum logic [1:0] {
		SDI_IDLE,
		SDI_SHIFT,
		SDI_WAIT_RISE
	} sdi_state_e;
endpackage : sdi_pkg

/* File: logic/sdi_serial_input.sv */
`timescale 1ns/1ps
`include "sdi_consts.svh"
module sdi_serial_input
	import sdi_pkg::*;
(
	// clock and reset
	input  wire logic                      CLK,
	input  wire logic                      NRST,
	// serial pins from the host
	input  wire logic                      SCLK,
	input  wire logic                      SYNC_N,
	input  wire logic                      DIN,
	// converter side
	output logic [`SDI_CODE_BITS-1:0]      ANALOG_OUTPUT_VOLTAGE_CODE,
	output logic [`SDI_PD_MSB-`SDI_PD_LSB:0] POWER_DOWN_MODE,
	output logic                           CODE_UPDATE,
	output logic                           FRAME_ABORT
);
	// synchronisers: first stage read only by the second
	logic [1:0] sclk_s;
	logic [1:0] sync_s;
	logic [1:0] din_s;
	logic       sclk_d_r;
	logic       sync_d_r;

	sdi_state_e state_r;
	sdi_state_e state_nxt;
	sdi_word_t  shift_r;
	sdi_word_t  shift_nxt;
	sdi_cnt_t   cnt_r;
	sdi_cnt_t   cnt_nxt;
	logic       push;
	logic       push_ready;
	logic       abort_nxt;
	logic       abort_r;

	logic       pop_valid;
	sdi_word_t  pop_word;
	sdi_code_t  code_r;
	sdi_code_t  code_nxt;
	logic [`SDI_PD_MSB-`SDI_PD_LSB:0] pd_r;
	logic [`SDI_PD_MSB-`SDI_PD_LSB:0] pd_nxt;
	logic       upd_r;

	logic       sclk_fall;
	logic       sync_rise;
	logic       frame_on;

	// next bit count; shared by the counter and the word-complete test
	function automatic sdi_cnt_t cnt_step(input sdi_cnt_t c);
		cnt_step = c + `SDI_CNT_ONE;
	endfunction : cnt_step

	// bring pins into the CLK domain
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			sclk_s   <= 2'h0;
			sync_s   <= 2'h3;
			din_s    <= 2'h0;
			sclk_d_r <= 1'b0;
			sync_d_r <= 1'b1;
		end else begin
			sclk_s   <= {sclk_s[0], SCLK};
			sync_s   <= {sync_s[0], SYNC_N};
			din_s    <= {din_s[0], DIN};
			sclk_d_r <= sclk_s[1];
			sync_d_r <= sync_s[1];
		end
	end

	// edge detection on synchronised pins
	assign sclk_fall = sclk_d_r && !sclk_s[1];
	assign sync_rise = !sync_d_r && sync_s[1];
	assign frame_on  = !sync_s[1];

	// frame sequencer next values
	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		cnt_nxt   = cnt_r;
		push      = 1'b0;
		abort_nxt = 1'b0;
		case (state_r)
			SDI_IDLE: begin
				cnt_nxt = `SDI_CNT_ZERO;
				if (frame_on) begin
					state_nxt = SDI_SHIFT;
				end
			end
			SDI_SHIFT: begin
				if (!frame_on) begin
					// early rise: partial word dropped
					state_nxt = SDI_IDLE;
					cnt_nxt   = `SDI_CNT_ZERO;
					abort_nxt = 1'b1;
				end else if (sclk_fall) begin
					shift_nxt = {shift_r[`SDI_WORD_BITS-2:0], din_s[1]};
					cnt_nxt   = cnt_step(cnt_r);
					if (cnt_step(cnt_r) == `SDI_LAST_BIT) begin
						state_nxt = SDI_WAIT_RISE;
					end
				end
			end
			SDI_WAIT_RISE: begin
				// word is complete; hand it over, then ignore clocks until frame closes
				if (cnt_r == `SDI_LAST_BIT) begin
					push = push_ready;
					if (push_ready) begin
						cnt_nxt = `SDI_CNT_ZERO;
					end
				end
				if (!frame_on && cnt_r != `SDI_LAST_BIT) begin
					state_nxt = SDI_IDLE;
				end
			end
			default: state_nxt = SDI_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_r <= SDI_IDLE;
			shift_r <= `SDI_WORD_RST;
			cnt_r   <= `SDI_CNT_ZERO;
			abort_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			cnt_r   <= cnt_nxt;
			abort_r <= abort_nxt;
		end
	end

	// small buffer decouples frame end from converter load
	sdi_fifo #(
		.WIDTH (`SDI_WORD_BITS),
		.DEPTH (`SDI_FIFO_DEPTH)
	) u_fifo (
		.CLK       (CLK),
		.NRST      (NRST),
		.in_valid  (push),
		.in_ready  (push_ready),
		.in_data   (shift_r),
		.out_valid (pop_valid),
		.out_ready (1'b1),
		.out_data  (pop_word)
	);

	// converter code and power-down load only from whole words
	always_comb begin
		code_nxt = code_r;
		pd_nxt   = pd_r;
		if (pop_valid) begin
			code_nxt = pop_word[`SDI_CODE_MSB:0];
			pd_nxt   = pop_word[`SDI_PD_MSB:`SDI_PD_LSB];
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			code_r <= `SDI_CODE_RST;
			pd_r   <= `SDI_PD_RST;
			upd_r  <= 1'b0;
		end else begin
			code_r <= code_nxt;
			pd_r   <= pd_nxt;
			upd_r  <= pop_valid;
		end
	end

	assign ANALOG_OUTPUT_VOLTAGE_CODE = code_r;
	assign POWER_DOWN_MODE            = pd_r;
	assign CODE_UPDATE                = upd_r;
	assign FRAME_ABORT                = abort_r;

	// sync_rise kept for the abort check below
	AST_ABORT_KEEPS_CODE: assert property (@(posedge CLK) disable iff (!NRST)
		(state_r == SDI_SHIFT && !frame_on) |=> (code_r == $past(code_r) && !upd_r))
		else $error("code changed on aborted frame");
	AST_CNT_CLEAR_IDLE: assert property (@(posedge CLK) disable iff (!NRST)
		(state_r == SDI_IDLE) |-> (cnt_r == `SDI_CNT_ZERO))
		else $error("bit counter not clear between frames");
	AST_NO_SHIFT_OUTSIDE: assert property (@(posedge CLK) disable iff (!NRST)
		(sync_s[1] && sync_d_r) |=> $stable(shift_r))
		else $error("shift register moved with frame select high");
	AST_SHIFT_ON_FALL: assert property (@(posedge CLK) disable iff (!NRST)
		(state_r == SDI_SHIFT && frame_on && sclk_fall) |=> (shift_r[0] == $past(din_s[1])))
		else $error("bit not shifted on falling edge");
	AST_UPDATE_AFTER_16: assert property (@(posedge CLK) disable iff (!NRST)
		(state_r == SDI_SHIFT && frame_on && sclk_fall && cnt_r == `SDI_LAST_BIT - `SDI_CNT_ONE) |-> ##[2:8] upd_r)
		else $error("code not updated after full word");
	AST_CODE_FROM_WORD: assert property (@(posedge CLK) disable iff (!NRST)
		pop_valid |=> (code_r == $past(pop_word[`SDI_CODE_MSB:0])))
		else $error("code not taken from word");
	AST_PD_FROM_WORD: assert property (@(posedge CLK) disable iff (!NRST)
		$changed(pd_r) |-> $past(pop_valid))
		else $error("power-down changed outside a completed frame");
	AST_ZERO_UNTIL_WRITE: assert property (@(posedge CLK) disable iff (!NRST)
		$changed(code_r) |-> $past(pop_valid))
		else $error("code left zero without a write");
	AST_RISE_SEEN: assert property (@(posedge CLK) disable iff (!NRST)
		(sync_rise && state_r == SDI_SHIFT) |=> abort_r)
		else $error("early rise not flagged");

	// a finished word may wait for the buffer, so only the other states must clear
	AST_CNT_CLEAR_HIGH: assert property (@(posedge CLK) disable iff (!NRST)
		(!frame_on && state_r != SDI_WAIT_RISE) |=> (cnt_r == `SDI_CNT_ZERO))
		else $error("bit counter kept with frame select high");
	AST_ABORT_ONE_CYCLE: assert property (@(posedge CLK) disable iff (!NRST)
		abort_r |=> !abort_r)
		else $error("abort flag stood more than one cycle");
	AST_PD_WITH_UPDATE: assert property (@(posedge CLK) disable iff (!NRST)
		upd_r |-> (pd_r == $past(pop_word[`SDI_PD_MSB:`SDI_PD_LSB])))
		else $error("power-down field not taken with the update");
endmodule : sdi_serial_input

/* File: testbench/sdi_host_model.sv */
`timescale 1ns/1ps
module sdi_host_model (
	// clock
	input  wire logic clk,
	// serial pins toward the device
	output logic      sclk,
	output logic      sync_n,
	output logic      din
);
	// idle: clock parked high, frame closed
	initial begin
		sclk = 1'b1;
		sync_n = 1'b1;
		din = 1'b0;
	end
	// pin changes land just after a system edge
	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask : ticks
	// one frame, msb first; the word carries the mode bits as well
	task automatic send(input logic [31:0] w, input int nbits);
		sync_n <= 1'b0;
		ticks(4);
		for (int i = nbits - 1; i >= 0; i--) begin
			din <= w[i];
			ticks(4);
			sclk <= 1'b0;
			ticks(4);
			sclk <= 1'b1;
		end
		ticks(4);
		sync_n <= 1'b1;
		din <= ~din; // released line must not keep the last bit
		ticks(8);
	endtask : send
endmodule : sdi_host_model

/* File: testbench/serial_dac_input_interface_tb.sv */
`timescale 1ns/1ps
`include "sdi_consts.svh"
module serial_dac_input_interface_tb;
	import sdi_pkg::*;
	logic                      CLK = 1'b0;
	logic                      NRST = 1'b0;
	logic                      SCLK;
	logic                      SYNC_N;
	logic                      DIN;
	logic [`SDI_CODE_BITS-1:0] code;
	logic [1:0]                pd;
	logic                      upd;
	logic                      abt;
	int                        fails = 0;
	int                        checked = 0;
	int                        n_upd = 0;
	int                        n_abt = 0;
	int                        e_upd = 0;
	int                        e_abt = 0;
	int                        e_code = 0;
	int                        e_pd = 0;
	logic [15:0]               exp_q[$];
	// clock and design
	always #50 CLK = ~CLK;
	sdi_host_model u_host (.clk(CLK), .sclk(SCLK), .sync_n(SYNC_N), .din(DIN));
	sdi_serial_input u_dut (.CLK(CLK), .NRST(NRST), .SCLK(SCLK), .SYNC_N(SYNC_N), .DIN(DIN),
		.ANALOG_OUTPUT_VOLTAGE_CODE(code), .POWER_DOWN_MODE(pd), .CODE_UPDATE(upd), .FRAME_ABORT(abt));
	// pulses stand one cycle; look mid-cycle where outputs are settled
	always @(negedge CLK) begin
		if (upd === 1'b1) begin
			n_upd++;
			if (exp_q.size() > 0) check(16'({pd, code}), exp_q.pop_front());
			else check(16'(upd), 16'h0000);
		end
		if (abt === 1'b1) n_abt++;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict
	// one frame, then compare against the reference counts and values
	task automatic frame(input logic [15:0] wd, input int nbits);
		logic [31:0] x;
		x = {16'h0000, wd};
		if (nbits >= 16) begin
			x = x << (nbits - 16); // spare clocks after bit 16 carry zeros
			e_code = wd[11:0];
			e_pd = wd[13:12];
			e_upd++;
			exp_q.push_back({2'b00, wd[13:0]});
		end else begin
			x = x >> (16 - nbits);
			e_abt++;
		end
		u_host.send(x, nbits);
		check(16'(n_upd), 16'(e_upd));
		check(16'(n_abt), 16'(e_abt));
		check(16'(code), 16'(e_code));
		check(16'(pd), 16'(e_pd));
		check(16'(exp_q.size()), 16'h0000);
	endtask : frame
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge CLK);
		fails++;
		print_verdict();
	end
	initial begin
		void'($urandom(93));
		repeat (12) @(posedge CLK);
		NRST <= 1'b1;
		u_host.ticks(4);
		check(16'(code), 16'h0000);
		check(16'(pd), 16'h0000);
		frame(16'(~$urandom), 10);
		$display("test reset_hold done");
		frame(16'hFFFF, 16);
		frame(16'h0000, 16);
		for (int i = 0; i < 8; i++) frame(16'($urandom), 16);
		$display("test full_words done");
		frame(16'($urandom), 15);
		frame(16'($urandom), 1);
		frame(16'($urandom), 16);
		$display("test abort done");
		frame(16'($urandom), 20);
		frame(16'($urandom), 16);
		$display("test overrun done");
		// reset again between frames: code and mode must drop back to zero
		NRST <= 1'b0;
		u_host.ticks(2);
		check(16'(code), 16'h0000);
		check(16'(pd), 16'h0000);
		check(16'(upd), 16'h0000);
		NRST <= 1'b1;
		e_code = 0;
		e_pd = 0;
		u_host.ticks(4);
		frame(16'($urandom), 12);
		frame(16'($urandom), 16);
		$display("test mid_reset done");
		print_verdict();
	end
endmodule : serial_dac_input_interface_tb
